// File: xram_page_and_device_id_regs.sv
// page register and read-only identity registers on the register bus
// assumes the core gives a register page, address, read and write strobes
// register map seen by the core, by register page and address:
//   0xAA, any page : page select, bits 1:0 writable, bits 7:2 hard zero
//   0xAB, page 0x00: derivative code, read only
//   0xAC, page 0x00: revision code, read only
//   0xAB, page 0x0F: serial byte zero, read only
//   0xAC, page 0x0F: serial byte one, read only
//   0xAD, page 0x0F: serial byte two, read only
//   0xAE, page 0x0F: serial byte three, read only
// every other address or page reads 0x00 with the hit flag low.
//
// timing on the register bus:
//   a strobe is taken on the rising edge at which it is high
//   read data and the hit flag appear on the next edge
//   read data then holds until the next read, the hit flag lasts one cycle
//   a write to the page register shows on the page field one edge later
//   a read in the same cycle as a page write returns the old page value
//
// hazards and limitations:
//   identity and serial values are parameters, so no write can touch them;
//   firmware that treats the serial bytes as scratch will read back the
//   factory values, never what it wrote
//   the page field feeds the address former directly, so a page write and an
//   operand access in one cycle still use the old page
//   the address former does not block page three; it only raises a flag,
//   and the memory beside this block forces the read data to zero
`include "xram_id_params.svh"
module xram_page_and_device_id_regs #(
    parameter logic [7:0]  DERIVATIVE_CODE = 8'h5A, // arbitrary value
    parameter logic [7:0]  REVISION_CODE   = 8'h3C, // arbitrary value
    parameter logic [31:0] SERIAL_NUMBER   = 32'h1234_5678 // arbitrary value
) (
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rst_b,
    // register bus from the core
    input  wire xram_id_pkg::byte_t   regPage,
    input  wire xram_id_pkg::byte_t   regAddr,
    input  wire logic                 regWrite,
    input  wire logic                 regRead,
    input  wire xram_id_pkg::byte_t   regWdata,
    output      xram_id_pkg::byte_t   regRdata,
    output      logic                 regHit,
    // 8-bit operand data RAM access
    input  wire xram_id_pkg::byte_t   ramOperand,
    input  wire logic                 ramShortAccess,
    output      logic [15:0]          ramAddr,
    output      logic                 ramBlank,
    // page field for other logic
    output      xram_id_pkg::page_t   page_field
);
    // register page qualifiers
    wire logic               pageZero;
    wire logic               pageF;
    // address matches before the page is taken into account
    wire logic               atPage;
    wire logic               atDeriv;
    wire logic               atRev;
    wire logic               atSerTop;
    wire logic               atSerTwo;
    wire logic               atSerOne;
    wire logic               atSerLow;
    // register hits, at most one high at a time
    wire logic               hitPage;
    wire logic               hitDeriv;
    wire logic               hitRev;
    wire logic               hitSerTop;
    wire logic               hitSerTwo;
    wire logic               hitSerOne;
    wire logic               hitSerLow;
    wire logic               anyHit;
    // read-back byte of each register
    wire xram_id_pkg::byte_t pageByte;
    wire xram_id_pkg::byte_t derivByte;
    wire xram_id_pkg::byte_t revByte;
    wire xram_id_pkg::byte_t serTopByte;
    wire xram_id_pkg::byte_t serTwoByte;
    wire xram_id_pkg::byte_t serOneByte;
    wire xram_id_pkg::byte_t serLowByte;
    // gated terms of the and-or read mux
    wire xram_id_pkg::byte_t pageTerm;
    wire xram_id_pkg::byte_t derivTerm;
    wire xram_id_pkg::byte_t revTerm;
    wire xram_id_pkg::byte_t serTopTerm;
    wire xram_id_pkg::byte_t serTwoTerm;
    wire xram_id_pkg::byte_t serOneTerm;
    wire xram_id_pkg::byte_t serLowTerm;
    wire xram_id_pkg::byte_t hitData;
    wire xram_id_pkg::byte_t selData;
    // page register write path
    wire logic               pageWrite;
    xram_id_pkg::page_t      next_page;

    // register page qualifiers; only pages zero and F carry identity bytes
    assign pageZero = (regPage == `REG_PAGE_ZERO);
    assign pageF    = (regPage == `REG_PAGE_F);

    // raw address matches; 0xAB and 0xAC are shared between two pages
    assign atPage   = (regAddr == `PAGE_SELECT_ADDR);
    assign atDeriv  = (regAddr == `DERIV_ADDR);
    assign atRev    = (regAddr == `REVISION_ADDR);
    assign atSerTop = (regAddr == `SERIAL_TOP_ADDR);
    assign atSerTwo = (regAddr == `SERIAL_TWO_ADDR);
    assign atSerOne = (regAddr == `SERIAL_ONE_ADDR);
    assign atSerLow = (regAddr == `SERIAL_LOW_ADDR);

    // page-qualified hits; the page register ignores the page on purpose
    assign hitPage   = atPage;
    assign hitDeriv  = pageZero && atDeriv;
    assign hitRev    = pageZero && atRev;
    assign hitSerTop = pageF && atSerTop;
    assign hitSerTwo = pageF && atSerTwo;
    assign hitSerOne = pageF && atSerOne;
    assign hitSerLow = pageF && atSerLow;
    assign anyHit    = hitPage | hitDeriv | hitRev |
                       hitSerTop | hitSerTwo | hitSerOne | hitSerLow;

    // upper six bits are hard zero, so only the field can show in the read-back byte
    assign pageByte = {6'h00, page_field};

    // identity bytes are parameters, so nothing on the bus can overwrite them
    assign derivByte  = DERIVATIVE_CODE;
    assign revByte    = REVISION_CODE;
    assign serTopByte = SERIAL_NUMBER[31:24];
    assign serTwoByte = SERIAL_NUMBER[23:16];
    assign serOneByte = SERIAL_NUMBER[15:8];
    assign serLowByte = SERIAL_NUMBER[7:0];

    // and-or mux: the hits are exclusive, so no priority chain is needed
    assign pageTerm   = pageByte & {8{hitPage}};
    assign derivTerm  = derivByte & {8{hitDeriv}};
    assign revTerm    = revByte & {8{hitRev}};
    assign serTopTerm = serTopByte & {8{hitSerTop}};
    assign serTwoTerm = serTwoByte & {8{hitSerTwo}};
    assign serOneTerm = serOneByte & {8{hitSerOne}};
    assign serLowTerm = serLowByte & {8{hitSerLow}};
    assign hitData    = pageTerm | derivTerm | revTerm |
                        serTopTerm | serTwoTerm | serOneTerm | serLowTerm;

    // unmapped reads return the default byte rather than stale data
    assign selData = anyHit ? hitData : `READ_DEFAULT;

    // only the low field takes write data; identity writes fall away
    assign pageWrite = regWrite && hitPage;
    assign next_page = pageWrite ? regWdata[`PAGE_FIELD_MSB:0]
                                 : page_field;

    // page register, cleared on reset
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            page_field <= `PAGE_FIELD_RESET;
        else
            page_field <= next_page;
    end

    // read data registered one cycle after the strobe; held otherwise
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            regRdata <= `READ_DEFAULT;
            regHit   <= 1'b0;
        end
        else
        begin
            regHit <= regRead && anyHit;
            if (regRead)
                regRdata <= selData;
        end
    end

    // address former uses the current page field
    xram_addr_former u_addr (
        .mclk        (mclk),
        .rst_b       (rst_b),
        .page        (page_field),
        .operand     (ramOperand),
        .shortAccess (ramShortAccess),
        .ramAddr     (ramAddr),
        .ramBlank    (ramBlank)
    );
endmodule

// File: xram_id_params.svh
// constants for the data RAM page register and the identity registers
// assumes an 8-bit register bus with a selectable register page
`ifndef XRAM_ID_PARAMS_SVH
`define XRAM_ID_PARAMS_SVH
`define PAGE_SELECT_ADDR    8'hAA
`define DERIV_ADDR          8'hAB
`define REVISION_ADDR       8'hAC
`define SERIAL_TOP_ADDR     8'hAE
`define SERIAL_TWO_ADDR     8'hAD
`define SERIAL_ONE_ADDR     8'hAC
`define SERIAL_LOW_ADDR     8'hAB
`define REG_PAGE_ZERO       8'h00
`define REG_PAGE_F          8'h0F
`define PAGE_FIELD_MSB      1
`define PAGE_FIELD_RESET    2'h0
`define BLANK_PAGE          2'h3
`define READ_DEFAULT        8'h00
`endif

// File: xram_id_pkg.sv
// shared types for the page and identity register block
// assumes nothing beyond the constants header
package xram_id_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [1:0] page_t;
endpackage

// File: xram_addr_former.sv
// forms the 16-bit data RAM address for an 8-bit operand access
// assumes page and operand come from the same clock domain
`include "xram_id_params.svh"
module xram_addr_former (
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rst_b,
    // inputs
    input  wire xram_id_pkg::page_t   page,
    input  wire xram_id_pkg::byte_t   operand,
    input  wire logic                 shortAccess,
    // outputs
    output      logic [15:0]          ramAddr,
    output      logic                 ramBlank
);
    wire logic [15:0] formedAddr;
    // the page is the upper byte, its top six bits always zero
    assign formedAddr = {6'h00, page, operand};

    // registered so the top-level outputs come from flip-flops
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ramAddr  <= 16'h0000;
            ramBlank <= 1'b0;
        end
        else if (shortAccess)
        begin
            ramAddr  <= formedAddr;
            ramBlank <= (page == `BLANK_PAGE);
        end
    end
endmodule

// File: xram_id_chk.sv
// checker for the page register, address former and identity reads
// assumes it is bound to the register block top and sees only its ports
module xram_id_chk #(
    parameter logic [7:0]  DERIVATIVE_CODE = 8'h5A,
    parameter logic [7:0]  REVISION_CODE   = 8'h3C,
    parameter logic [31:0] SERIAL_NUMBER   = 32'h1234_5678
) (
    // clock, reset, strobes and flags
    input wire logic mclk, rst_b, regWrite, regRead, regHit, ramShortAccess, ramBlank,
    // bus and address values
    input wire xram_id_pkg::byte_t regPage, regAddr, regWdata, regRdata, ramOperand,
    input wire logic [15:0]        ramAddr,
    input wire xram_id_pkg::page_t page_field
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // a read on a given page and address; the page write sequence is used by one check, a_page_wr
    sequence s_rd(a, p); regRead && regAddr == a && regPage == p; endsequence
    sequence s_pgWr; regWrite && regAddr == 8'hAA; endsequence
a_addr_form:
    assert property (ramShortAccess |=> ramAddr == {6'h00, $past(page_field), $past(ramOperand)})
        else $error("formed address wrong");
a_ram_blank:
    assert property (ramShortAccess |=> ramBlank == ($past(page_field) == 2'h3))
        else $error("blank page flag wrong");
a_page_wr:
    assert property (s_pgWr |=> {6'h00, page_field} == ($past(regWdata) & 8'h03))
        else $error("page write not taken");
a_page_hold:
    assert property (!(regWrite && regAddr == 8'hAA) |=> $stable(page_field))
        else $error("page changed without write");
a_page_rd:
    assert property (regRead && regAddr == 8'hAA |=> regHit && regRdata == {6'h00, $past(page_field)})
        else $error("page read wrong");
a_deriv_rd:
    assert property (s_rd(8'hAB, 8'h00) |=> regHit && regRdata == DERIVATIVE_CODE)
        else $error("derivative read wrong");
a_rev_rd:
    assert property (s_rd(8'hAC, 8'h00) |=> regHit && regRdata == REVISION_CODE)
        else $error("revision read wrong");
a_serial_rd:
    assert property (regRead && regPage == 8'h0F && regAddr inside {[8'hAB:8'hAE]} |=>
        regHit && regRdata == SERIAL_NUMBER[8*($past(regAddr)-8'hAB) +: 8])
        else $error("serial read wrong");
a_unmapped_rd:
    assert property (regRead && regAddr < 8'hAA |=> !regHit && regRdata == 8'h00)
        else $error("unmapped read answered");
endmodule

// File: core_model.sv
// core side model: one register transfer per call, strobe held one cycle
// assumes the block answers one cycle after the strobe edge
module core_model (
    input  wire logic                mclk, regHit,
    input  wire xram_id_pkg::byte_t  regRdata,
    output xram_id_pkg::byte_t       regPage, regAddr, regWdata,
    output logic                     regWrite, regRead
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {regPage, regAddr, regWdata, regWrite, regRead} = 26'h0;
    // released address and write data lines show the inverse, strobes drop, page is kept
    // firmware here never relies on serial registers keeping writes
    task automatic xfer(input logic w, input xram_id_pkg::byte_t p, a, d, output logic [8:0] q);
        @(posedge mclk);
        #1 {regPage, regAddr, regWdata, regWrite, regRead} = {p, a, d, w, !w};
        @(posedge mclk);
        #1 {regAddr, regWdata, regWrite, regRead} = {~a, ~d, 2'b00};
        q = {regHit, regRdata};
    endtask
endmodule

// File: xram_page_and_device_id_regs_bench.sv
// bench: random page writes, address forming and identity reads
// assumes the core model drives the register bus, the bench the RAM side
module xram_page_and_device_id_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0]  DER = 8'h69;         // arbitrary value
    localparam logic [7:0]  REV = 8'h17;         // arbitrary value
    localparam logic [31:0] SER = 32'hA5C3_0F96; // arbitrary value
    logic mclk = 0, rst_b = 0, regWrite, regRead, regHit, ramShortAccess = 0, ramBlank;
    xram_id_pkg::byte_t regPage, regAddr, regWdata, regRdata, ramOperand = 8'h00, d, pg;
    xram_id_pkg::byte_t adr [6] = '{8'h80, 8'hA9, 8'hAB, 8'hAC, 8'hAD, 8'hAE};
    logic [15:0] ramAddr;
    xram_id_pkg::page_t page_field;
    logic [8:0] q;
    logic [31:0] seed = 32'd21411;
    int n_errors = 0, tests_run = 0;
    always #2.5 mclk = ~mclk;
    function automatic xram_id_pkg::byte_t xs();
        seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
        return seed[7:0];
    endfunction
    // hit flag and data the core should see for one read
    function automatic logic [8:0] expId(input xram_id_pkg::byte_t p, a);
        if (p == 8'h0F && a inside {[8'hAB:8'hAE]}) return {1'b1, SER[8*(a-8'hAB) +: 8]};
        if (p == 8'h00 && a == 8'hAB) return {1'b1, DER};
        if (p == 8'h00 && a == 8'hAC) return {1'b1, REV};
        return 9'h000;
    endfunction
    task automatic check(input string nm, input logic [15:0] seen, exp);
        tests_run++;
        if (seen !== exp)
        begin
            $display("BAD %s expected %h seen %h", nm, exp, seen);
            n_errors++;
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    xram_page_and_device_id_regs #(.DERIVATIVE_CODE(DER), .REVISION_CODE(REV),
        .SERIAL_NUMBER(SER)) dut (.*);
    core_model cm (.*);
    initial
    begin
        repeat (6) @(posedge mclk);
        #1 rst_b = 1;
        check("page reset", page_field, 16'h0);
        check("rdata reset", regRdata, 16'h0);
        check("hit reset", regHit, 16'h0);
        check("addr reset", ramAddr, 16'h0);
        check("blank reset", ramBlank, 16'h0);
        // every page value once, random upper bits, then random pages
        for (int i = 0; i < 12; i++)
        begin
            d = xs();
            if (i < 4) d[1:0] = i[1:0];
            cm.xfer(1, xs(), 8'hAA, d, q);
            cm.xfer(0, xs(), 8'hAA, 8'h00, q);
            check("page read", q, {1'b1, 6'h00, d[1:0]});
            ramOperand = xs();
            ramShortAccess = 1;
            @(posedge mclk);
            #1 ramShortAccess = 0;
            check("ram addr", ramAddr, {6'h00, d[1:0], ramOperand});
            check("ram blank", ramBlank, d[1:0] == 2'h3);
        end
        $display("test page done");
        rst_b = 0;
        #2 check("page mid reset", page_field, 16'h0);
        @(posedge mclk);
        #1 rst_b = 1;
        // write junk first: identity values must survive it
        for (int k = 0; k < 12; k++)
        begin
            pg = (k < 6) ? 8'h00 : 8'h0F;
            cm.xfer(1, pg, adr[k%6], xs(), q);
            cm.xfer(0, pg, adr[k%6], 8'h00, q);
            check("id read", q, expId(pg, adr[k%6]));
        end
        $display("test identity done");
        end_of_test();
    end
    initial
    begin
        #100000 n_errors++;
        end_of_test();
    end
endmodule
bind xram_page_and_device_id_regs xram_id_chk #(.DERIVATIVE_CODE(DERIVATIVE_CODE),
    .REVISION_CODE(REVISION_CODE), .SERIAL_NUMBER(SERIAL_NUMBER)) chk (.*);
